//--- hdl/maskable_irq_priority_vector.sv
// Priority resolver and vector generator for twenty maskable sources
`timescale 1ns/1ns
module maskable_irq_priority_vector
	import irq_vec_pkg::*;
(
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	// Event sources
	input  wire irq_events_t         events,
	input  wire logic                lowvolt_reset_select_bit,
	// Mask and priority-group flags, bit n is default priority n
	input  wire logic [NUM_SRC-1:0]  mask_flags,
	input  wire logic [NUM_SRC-1:0]  low_group_flags,
	input  wire logic                irq_enable,
	// CPU side
	output irq_req_t                 req,
	input  wire logic                ack,
	input  wire logic                service_done
);

	////////////////////////////////////////////////////////////////////////
	// Map physical triggers to priority-ordered request lines

	// twenty handled sources
	// Sources of priority 20 and beyond are resolved outside this block
	logic [NUM_SRC-1:0] raise;
	logic [NUM_SRC-1:0] pend_q;
	logic [NUM_SRC-1:0] pend_d;
	logic               in_svc_q;
	logic               in_svc_d;
	logic               svc_high_q;
	logic               svc_high_d;
	irq_req_t           req_d;

	// Vector is a fixed stride from the first maskable slot
	function automatic logic [15:0] vec_of(input logic [IDX_W-1:0] idx);
		vec_of = VEC_BASE + VEC_STEP * {11'h000, idx};
	endfunction

	always_comb
	begin
		raise[0]     = events.low_voltage_irq & ~lowvolt_reset_select_bit;
		raise[6:1]   = events.pin_edge_irq;
		raise[7]     = events.uart_b_rx_error_irq;
		raise[8]     = events.uart_b_rx_end_irq;
		raise[9]     = events.uart_b_tx_end_irq;
		raise[10]    = events.sync_serial_end | events.uart_a_tx_end;
		raise[11]    = events.timer_h_one_match_irq;
		raise[12]    = events.timer_h_zero_match_irq;
		raise[13]    = events.event_timer_a_match_irq;
		raise[19]    = events.event_timer_b_match_irq;
		// wide timer slots, match or capture decided by the timer
		raise[14]    = events.wide_timer_chan0_irq;
		raise[15]    = events.wide_timer_chan1_irq;
		raise[16]    = events.adc_done_irq;
		raise[17]    = events.uart_a_rx_irq | events.uart_a_rx_err;
		raise[18]    = events.watch_interval_irq;
	end

	////////////////////////////////////////////////////////////////////////
	// Resolve winner and track the service in progress

	always_comb
	begin
		logic [IDX_W-1:0] win;
		logic             found;
		logic             win_high;
		logic             may_take;
		may_take = 1'b0;
		win      = '0;
		found    = 1'b0;
		win_high = 1'b0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (pend_q[i] && !mask_flags[i])
			begin
				win   = IDX_W'(i);
				found = 1'b1;
			end
		end
		// high group first, then default order inside it
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (pend_q[i] && !mask_flags[i] && !low_group_flags[i])
			begin
				win      = IDX_W'(i);
				win_high = 1'b1;
			end
		end
		// nesting only when a high request preempts a low service
		may_take     = irq_enable & (!in_svc_q | (win_high & !svc_high_q));
		// taken offer withdrawn
		// A taken offer would otherwise stand one more cycle and invite a second take
		req_d.valid  = found & may_take & ~(ack & req.valid);
		req_d.prio   = found ? win : IDX_W'(PRIO_NONE);
		req_d.vector = found ? vec_of(win) : 16'h0000;
		// latch until acknowledged; a new event beats the clear
		pend_d       = pend_q;
		if (ack && req.valid)
			pend_d[req.prio] = 1'b0;
		pend_d       = pend_d | raise;
		in_svc_d     = in_svc_q;
		svc_high_d   = svc_high_q;
		if (service_done)
		begin
			in_svc_d   = 1'b0;
			svc_high_d = 1'b0;
		end
		if (ack && req.valid)
		begin
			in_svc_d   = 1'b1;
			svc_high_d = ~low_group_flags[req.prio];
		end
	end

	// Registers only
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend_q     <= '0;
			in_svc_q   <= 1'b0;
			svc_high_q <= 1'b0;
			req        <= '0;
		end
		else
		begin
			pend_q     <= pend_d;
			in_svc_q   <= in_svc_d;
			svc_high_q <= svc_high_d;
			req        <= req_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_lvi_raise;
		events.low_voltage_irq && !lowvolt_reset_select_bit;
	endsequence

	// CPU takes the standing offer
	sequence s_taken;
		ack && req.valid;
	endsequence

	// Take with no fresh event for the same slot, so the clear must show
	sequence s_taken_clean;
		ack && req.valid && !raise[req.prio];
	endsequence

	AST_LVI_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_lvi_raise |=> pend_q[0])
		else $error("low-voltage event not latched");
	AST_LVI_RESET_MODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!pend_q[0] && lowvolt_reset_select_bit && events.low_voltage_irq) |=> !pend_q[0])
		else $error("low-voltage pending in reset mode");
	AST_VECTOR_MAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		req.valid |-> req.vector == 16'h0004 + {10'h000, req.prio, 1'b0})
		else $error("vector does not match priority");
	AST_SHARED_SERIAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.uart_a_tx_end |=> pend_q[10])
		else $error("shared serial slot not raised");
	AST_SHARED_RX: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.uart_a_rx_err |=> pend_q[17])
		else $error("first UART rx error not raised");
	AST_PEND_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(pend_q[18] && !(ack && req.valid)) |=> pend_q[18])
		else $error("pending request lost without acknowledge");
	AST_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(req.valid && req.prio > 0 && !low_group_flags[0])
			|-> ($past(mask_flags[0]) || !$past(pend_q[0]) || $past(low_group_flags[0]))
		)
		else $error("lower priority chosen over priority 0");
	AST_NO_NEST_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(req_d.valid && in_svc_q) |-> (!svc_high_q && !low_group_flags[req_d.prio]))
		else $error("offer made inside a service it may not nest over");
	AST_ADC_SLOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.adc_done_irq |=> pend_q[16])
		else $error("converter request not latched");

	// Slot mapping of the remaining sources
	AST_PIN_EDGE_SLOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.pin_edge_irq[5] |=> pend_q[6])
		else $error("last pin edge request not latched");
	AST_UART_B_SLOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.uart_b_rx_end_irq |=> pend_q[8])
		else $error("second UART rx end not latched");
	AST_SYNC_SERIAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.sync_serial_end |=> pend_q[10])
		else $error("sync serial end not raised");
	AST_TIMER_H_SLOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.timer_h_zero_match_irq |=> pend_q[12])
		else $error("timer H0 match not latched");
	AST_EVENT_B_SLOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.event_timer_b_match_irq |=> pend_q[19])
		else $error("event timer B match not latched");
	AST_WIDE_SLOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.wide_timer_chan1_irq |=> pend_q[15])
		else $error("wide timer channel 1 not latched");
	AST_UART_A_RX: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.uart_a_rx_irq |=> pend_q[17])
		else $error("first UART rx end not raised");
	AST_WATCH_SLOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.watch_interval_irq |=> pend_q[18])
		else $error("watch interval request not latched");
	AST_LVI_VECTOR: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(req.valid && req.prio == '0) |-> req.vector == VEC_BASE)
		else $error("low-voltage vector wrong");

	// Offer and take bookkeeping
	AST_OFFER_PENDING: assert property (@(posedge ref_clk) disable iff (!rst_n)
		req.valid |-> pend_q[req.prio])
		else $error("offer for a source not pending");
	AST_ACK_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_taken_clean |=> !pend_q[$past(req.prio)])
		else $error("taken request still pending");
	AST_NO_STALE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_taken |=> !req.valid)
		else $error("taken offer still standing");

endmodule

//--- hdl/irq_vec_pkg.sv
// Constants and types for the maskable interrupt priority and vector block
// Functional notes
// - Simultaneous pending requests are served high group first, lowest priority number first within a group.
// - Thirty sources total, twenty-seven in small variants; twenty handled here.
// - Low-voltage request: priority 0, vector 0004H, only when reset-select bit 0.
// - Six pin edge requests: priorities 1 to 6, vectors 0006H to 0010H.
// - Second UART error, rx end, tx end: priorities 7-9, vectors 0012H-0016H.
// - Sync serial end or first UART tx end share priority 10, vector 0018H.
// - Timer H1 match priority 11 at 001AH; timer H0 priority 12 at 001CH.
// - Event timer A priority 13 at 001EH; event timer B priority 19 at 002AH.
// - Wide timer channels: priorities 14,15, vectors 0020H,0022H, match or capture.
// - Converter done request: priority 16, vector 0024H.
// - First UART rx end or rx error share priority 17, vector 0026H.
// - Watch interval request: priority 18, vector 0028H.
// - High-group request may nest over a low-group service in progress.
package irq_vec_pkg;

	localparam int          NUM_SRC      = 20;
	localparam int          NUM_TOTAL    = 30;
	localparam int          NUM_TOTAL_SM = 27;
	localparam int          IDX_W        = 5;
	localparam logic [15:0] VEC_BASE     = 16'h0004;
	localparam logic [15:0] VEC_STEP     = 16'h0002;
	localparam int          PRIO_NONE    = 31;

	// Raw event inputs, one bit per physical trigger
	typedef struct packed {
		logic       watch_interval_irq;
		logic       uart_a_rx_err;
		logic       uart_a_rx_irq;
		logic       adc_done_irq;
		logic       wide_timer_chan1_irq;
		logic       wide_timer_chan0_irq;
		logic       event_timer_b_match_irq;
		logic       event_timer_a_match_irq;
		logic       timer_h_zero_match_irq;
		logic       timer_h_one_match_irq;
		logic       uart_a_tx_end;
		logic       sync_serial_end;
		logic       uart_b_tx_end_irq;
		logic       uart_b_rx_end_irq;
		logic       uart_b_rx_error_irq;
		logic [5:0] pin_edge_irq;
		logic       low_voltage_irq;
	} irq_events_t;

	// Answer presented to the CPU core
	typedef struct packed {
		logic             valid;
		logic [IDX_W-1:0] prio;
		logic [15:0]      vector;
	} irq_req_t;

endpackage

//--- verification/cpu_partner.sv
// CPU core model: takes offered vectors and ends a service only when fin is set at the take
`timescale 1ns/1ns
module cpu_partner
	import irq_vec_pkg::*;
(
	// Clock, reset and offer
	input  wire logic     ref_clk,
	input  wire logic     rst_n,
	input  wire irq_req_t req,
	input  wire logic     fin,
	// Replies
	output logic          ack,
	output logic          service_done
);
	// Random wait of 0 to 2 cycles so prompt and slow takes both occur
	initial
	begin
		logic ends;
		ack          = 1'b0;
		service_done = 1'b0;
		ends         = 1'b0;
		forever
		begin
			// Offer is looked at once it has settled after the edge
			@(posedge ref_clk);
			#1;
			if (rst_n === 1'b1 && req.valid === 1'b1)
			begin
				repeat ($urandom_range(2))
				begin
					@(posedge ref_clk);
					#1;
				end
				// Take only an offer that still stands
				if (req.valid === 1'b1)
				begin
					// End choice fixed at the take, so a later fin cannot close it early
					ends = fin;
					ack  = 1'b1;
					@(posedge ref_clk);
					#1 ack = 1'b0;
					// Without fin the service stays open, letting nesting be tried
					if (ends)
					begin
						@(posedge ref_clk);
						#1 service_done = 1'b1;
						@(posedge ref_clk);
						#1 service_done = 1'b0;
					end
				end
				repeat (2) @(posedge ref_clk);
			end
		end
	end
endmodule

//--- verification/tb_maskable_irq_priority_vector.sv
// Self-checking bench for the interrupt priority and vector block
`timescale 1ns/1ns
module tb_maskable_irq_priority_vector
	import irq_vec_pkg::*;
;
	// Event bit to default priority; shared slots 10 and 17 each take two bits
	function automatic int slot_of(input int b);
		case (b)
			11:      slot_of = 10;
			12:      slot_of = 11;
			13:      slot_of = 12;
			14:      slot_of = 13;
			15:      slot_of = 19;
			16:      slot_of = 14;
			17:      slot_of = 15;
			18:      slot_of = 16;
			19, 20:  slot_of = 17;
			21:      slot_of = 18;
			default: slot_of = b;
		endcase
	endfunction

	logic        ref_clk;
	logic        rst_n;
	logic [21:0] ev;
	logic [21:0] rv;
	logic        lvsel;
	logic [19:0] mask_flags;
	logic [19:0] low_group_flags;
	logic [19:0] m;
	logic [19:0] s;
	logic        fin;
	logic        irq_en;
	logic        ack;
	logic        service_done;
	irq_req_t    req;
	int          errors;
	int          n_compared;

	maskable_irq_priority_vector DUT (.ref_clk(ref_clk), .rst_n(rst_n), .events(ev),
		.lowvolt_reset_select_bit(lvsel), .mask_flags(mask_flags),
		.low_group_flags(low_group_flags), .irq_enable(irq_en), .req(req), .ack(ack),
		.service_done(service_done));
	cpu_partner partner (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .fin(fin), .ack(ack),
		.service_done(service_done));

	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input bit ok, input string msg);
		n_compared++;
		if (!ok)
		begin
			errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic pulse(input logic [21:0] v);
		ev = v;
		@(posedge ref_clk);
		#1 ev = '0;
	endtask

	// Expects offers in ascending slot order; a missing offer ends the run
	task automatic drain(input logic [19:0] sl);
		int e;
		int i;
		while (sl != '0)
		begin
			for (i = 0; i < 40 && req.valid !== 1'b1; i++)
				@(posedge ref_clk) #1;
			chk(req.valid === 1'b1, "no offer");
			if (req.valid !== 1'b1)
				report_and_stop();
			e = 0;
			while (!sl[e])
				e++;
			chk(req.prio === 5'(e) && req.vector === 16'h0004 + 16'(2 * e), "winner");
			sl[e] = 1'b0;
			for (i = 0; i < 40 && req.valid === 1'b1 && req.prio === 5'(e); i++)
				@(posedge ref_clk) #1;
			// An offer that is never withdrawn means the take was lost
			chk(!(req.valid === 1'b1 && req.prio === 5'(e)), "offer never taken");
			if (req.valid === 1'b1 && req.prio === 5'(e))
				report_and_stop();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst_n = 1'b0;
		ev = '0;
		lvsel = 1'b0;
		mask_flags = '0;
		low_group_flags = '0;
		fin = 1'b1;
		errors = 0;
		n_compared = 0;
		irq_en = 1'b1;
		void'($urandom(15520));
		repeat (8) @(posedge ref_clk);
		#1 chk(req === '0, "reset");
		rst_n = 1'b1;
		for (int b = 0; b < 22; b++)
		begin
			pulse(22'(1) << b);
			drain(20'(1) << slot_of(b));
		end
		$display("test single sources done");
		lvsel = 1'b1;
		pulse(22'h00_0001);
		repeat (10) @(posedge ref_clk) #1 chk(req.valid === 1'b0, "low-voltage taken");
		lvsel = 1'b0;
		$display("test low-voltage select done");
		// Disabled: the request is held but not offered until enabled again
		irq_en = 1'b0;
		pulse(22'h20_0000);
		repeat (6) @(posedge ref_clk) #1 chk(req.valid === 1'b0, "offer while disabled");
		irq_en = 1'b1;
		drain(20'h4_0000);
		$display("test enable done");
		// Only slot 5 high; slot 10 service left open, then 5 must nest over it
		low_group_flags = 20'hF_FFDF;
		fin = 1'b0;
		pulse(22'h00_0400);
		drain(20'h0_0400);
		fin = 1'b1;
		pulse(22'h00_2020);
		drain(20'h0_1020);
		low_group_flags = '0;
		$display("test nesting done");
		repeat (24)
		begin
			rv = 22'($urandom);
			m = 20'($urandom);
			s = '0;
			for (int b = 0; b < 22; b++)
				if (rv[b])
					s[slot_of(b)] = 1'b1;
			mask_flags = m;
			pulse(rv);
			drain(s & ~m);
			mask_flags = '0;
			drain(s & m);
		end
		$display("test random sets done");
		report_and_stop();
	end
endmodule
